/* File: common/frs_cfg.svh */
`ifndef FRS_CFG_SVH
`define FRS_CFG_SVH
// ==========================================================
// register width and bit positions (shift order)
`define FRS_NBITS 10
`define FRS_CNT_W 4
`define FRS_POS_A_HIGH_SHORT 0
`define FRS_POS_B_HIGH_SHORT 1
`define FRS_POS_C_HIGH_SHORT 2
`define FRS_POS_A_LOW_SHORT 3
`define FRS_POS_B_LOW_SHORT 4
`define FRS_POS_C_LOW_SHORT 5
`define FRS_POS_REGULATOR_UV 6
`define FRS_POS_BOOT_A_UV 7
`define FRS_POS_BOOT_B_UV 8
`define FRS_POS_BOOT_C_UV 9
// ==========================================================
// controller registers over apb (byte addresses)
`define FRS_OFF_CTRL 12'h000
`define FRS_OFF_STAT 12'h004
`define FRS_OFF_DATA 12'h008
`define FRS_OFF_IRQ 12'h00c
`define FRS_OFF_MASK 12'h010
`define FRS_CTRL_START 0
`define FRS_IRQ_DONE 0
`define FRS_IRQ_FAULT 1
`define FRS_IRQ_W 2
// ==========================================================
// link timing
`define FRS_HALF_NS 80
`define FRS_CLK_NS 4
`define FRS_HALF_CYC ((`FRS_HALF_NS + `FRS_CLK_NS - 1) / `FRS_CLK_NS)
`endif

/* File: common/frs_pkg.sv */
package frs_pkg;
  typedef enum logic [2:0] {
    FRS_IDLE = 3'b000,
    FRS_LOW = 3'b001,
    FRS_SAMPLE = 3'b011,
    FRS_HIGH = 3'b010,
    FRS_WAIT = 3'b110
  } frs_host_state_t;
endpackage : frs_pkg

/* File: common/frs_link_if.sv */
`timescale 1ns/1ns
interface frs_link_if;
  logic serial_out_o;
  logic serial_out_oe;
  logic serial_clock_o;
  logic serial_clock_oe_dev;
  logic serial_clock_oe_host;
  logic serial_out_i;
  logic serial_clock_i;
  // open-drain wire: any enabled driver pulls low, else pulled high
  assign serial_out_i = !serial_out_oe;
  assign serial_clock_i = !(serial_clock_oe_dev || serial_clock_oe_host);
  modport dev(output serial_out_o, output serial_out_oe, output serial_clock_o,
    output serial_clock_oe_dev, input serial_out_i, input serial_clock_i);
  modport host(output serial_clock_oe_host, input serial_out_i, input serial_clock_i);
endinterface : frs_link_if

/* File: hw/frs_device.sv */
`timescale 1ns/1ns
`include "frs_cfg.svh"
module frs_device
  import frs_pkg::*;
#(
  parameter int NBITS = `FRS_NBITS
) (
  input wire logic pclk,
  input wire logic presetn,
  frs_link_if.dev link,
  input wire logic [5:0] vds_fault,
  input wire logic gate_regulator_rail_uv,
  input wire logic [2:0] boot_uv,
  input wire logic vdd_uv,
  input wire logic over_temp,
  output logic [NBITS-1:0] fault_record_reg,
  output logic short_state_reg,
  output logic boot_state_reg
);
  logic clk_s1_reg, clk_s2_reg, clk_s3_reg;
  logic [`FRS_CNT_W-1:0] pos_reg;
  logic active_reg;
  logic fall, rise, read_done, latched_fault, uv_level, fault_present;
  logic [NBITS-1:0] set_bits;
  // ==========================================================
  // flag2 synchroniser and edge detect
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // flag2 is held low in reset, so no false edge follows release
      clk_s1_reg <= 1'b0;
      clk_s2_reg <= 1'b0;
      clk_s3_reg <= 1'b0;
    end else begin
      clk_s1_reg <= link.serial_clock_i;
      clk_s2_reg <= clk_s1_reg;
      clk_s3_reg <= clk_s2_reg;
    end
  end
  assign fall = clk_s3_reg && !clk_s2_reg;
  assign rise = !clk_s3_reg && clk_s2_reg;
  assign uv_level = gate_regulator_rail_uv || vdd_uv || boot_state_reg;
  assign latched_fault = short_state_reg || boot_state_reg;
  assign fault_present = short_state_reg || uv_level || vds_fault != 6'h00;
  assign set_bits = {boot_uv, gate_regulator_rail_uv, vds_fault};
  // the fall after the last bit is shown ends the readout
  assign read_done = active_reg && fall && pos_reg == `FRS_CNT_W'(NBITS - 1);
  // ==========================================================
  // fault record
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_record_reg <= '0;
    end else if (vdd_uv) begin
      fault_record_reg <= '0;
    end else if (read_done) begin
      fault_record_reg <= set_bits;
    end else begin
      fault_record_reg <= fault_record_reg | set_bits;
    end
  end
  // ==========================================================
  // latched fault states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      short_state_reg <= 1'b0;
      boot_state_reg <= 1'b0;
    end else if (vdd_uv || read_done) begin
      short_state_reg <= 1'b0;
      boot_state_reg <= 1'b0;
    end else begin
      short_state_reg <= short_state_reg || vds_fault != 6'h00;
      boot_state_reg <= boot_state_reg || boot_uv != 3'h0;
    end
  end
  // ==========================================================
  // readout pointer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_reg <= 1'b0;
      pos_reg <= '0;
    end else if (vdd_uv || !fault_present || read_done) begin
      active_reg <= 1'b0;
      pos_reg <= '0;
    end else if (fall && !active_reg) begin
      active_reg <= 1'b1;
      pos_reg <= '0;
    end else if (fall && active_reg) begin
      pos_reg <= pos_reg + 1'b1;
    end
  end
  // ==========================================================
  // open-drain flag drivers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link.serial_out_oe <= 1'b1;
      link.serial_clock_oe_dev <= 1'b1;
    end else if (vdd_uv) begin
      link.serial_out_oe <= 1'b0;
      link.serial_clock_oe_dev <= 1'b0;
    end else if (read_done) begin
      link.serial_out_oe <= 1'b1;
      link.serial_clock_oe_dev <= 1'b1;
    end else if (active_reg) begin
      link.serial_clock_oe_dev <= 1'b0;
      link.serial_out_oe <= (pos_reg < `FRS_CNT_W'(NBITS)) ?
        !fault_record_reg[pos_reg] : 1'b1;
    end else begin
      link.serial_clock_oe_dev <= !(fault_present || latched_fault);
      link.serial_out_oe <= !uv_level;
    end
  end
  assign link.serial_out_o = 1'b0;
  assign link.serial_clock_o = 1'b0;
  logic unused;
  assign unused = rise ^ over_temp;
endmodule : frs_device

/* File: hw/frs_host.sv */
// The implementer's own choices: the APB register port and the register addresses.
`timescale 1ns/1ns
`include "frs_cfg.svh"
module frs_host
  import frs_pkg::*;
#(
  parameter int NBITS = `FRS_NBITS,
  parameter int HALF = `FRS_HALF_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  frs_link_if.host link,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq
);
  frs_host_state_t st_reg;
  logic dat_s1_reg, dat_s2_reg, sck_s1_reg, sck_s2_reg;
  logic [15:0] tmr_reg;
  logic [3:0] nbit_reg;
  logic [NBITS-1:0] data_reg;
  logic [`FRS_IRQ_W-1:0] irq_stat_reg, irq_mask_reg;
  logic start, wr, fault_seen;
  assign wr = psel && penable && pwrite;
  assign start = wr && paddr == `FRS_OFF_CTRL && pwdata[`FRS_CTRL_START];
  assign fault_seen = sck_s2_reg && st_reg == FRS_IDLE;
  // ==========================================================
  // synchronisers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dat_s1_reg <= 1'b0;
      dat_s2_reg <= 1'b0;
      sck_s1_reg <= 1'b0;
      sck_s2_reg <= 1'b0;
    end else begin
      dat_s1_reg <= link.serial_out_i;
      dat_s2_reg <= dat_s1_reg;
      sck_s1_reg <= link.serial_clock_i;
      sck_s2_reg <= sck_s1_reg;
    end
  end
  // ==========================================================
  // readout sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= FRS_IDLE;
      tmr_reg <= '0;
      nbit_reg <= '0;
      data_reg <= '0;
      link.serial_clock_oe_host <= 1'b0;
    end else begin
      if (tmr_reg != 16'h0000) tmr_reg <= tmr_reg - 16'h0001;
      case (st_reg)
        FRS_IDLE: if (start && sck_s2_reg) begin
          link.serial_clock_oe_host <= 1'b1;
          tmr_reg <= 16'(HALF * 2);
          nbit_reg <= '0;
          st_reg <= FRS_LOW;
        end
        FRS_LOW: if (tmr_reg == 16'h0000) st_reg <= FRS_SAMPLE;
        FRS_SAMPLE: begin
          if (nbit_reg < 4'(NBITS)) data_reg[nbit_reg] <= dat_s2_reg;
          nbit_reg <= nbit_reg + 4'h1;
          link.serial_clock_oe_host <= 1'b0;
          tmr_reg <= 16'(HALF);
          st_reg <= FRS_HIGH;
        end
        FRS_HIGH: if (tmr_reg == 16'h0000) begin
          link.serial_clock_oe_host <= 1'b1;
          tmr_reg <= 16'(HALF * 2);
          st_reg <= (nbit_reg == 4'(NBITS)) ? FRS_WAIT : FRS_LOW;
        end
        FRS_WAIT: if (tmr_reg == 16'h0000) begin
          link.serial_clock_oe_host <= 1'b0;
          st_reg <= FRS_IDLE;
        end
        default: st_reg <= FRS_IDLE;
      endcase
    end
  end
  // ==========================================================
  // interrupts, w1c, set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_reg <= '0;
      irq_mask_reg <= '0;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~((wr && paddr == `FRS_OFF_IRQ) ?
        pwdata[`FRS_IRQ_W-1:0] : '0))
        | {fault_seen, st_reg == FRS_WAIT && tmr_reg == 16'h0000};
      if (wr && paddr == `FRS_OFF_MASK) irq_mask_reg <= pwdata[`FRS_IRQ_W-1:0];
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) irq <= 1'b0;
    else irq <= |(irq_stat_reg & ~irq_mask_reg);
  end
  // ==========================================================
  // apb slave, no wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      prdata <= '0;
      if (psel && !penable) begin
        case (paddr)
          `FRS_OFF_CTRL: prdata <= 32'h0;
          `FRS_OFF_STAT: prdata <= {27'h0, dat_s2_reg, sck_s2_reg, st_reg != FRS_IDLE, 2'b00};
          `FRS_OFF_DATA: prdata <= 32'(data_reg);
          `FRS_OFF_IRQ: prdata <= 32'(irq_stat_reg);
          `FRS_OFF_MASK: prdata <= 32'(irq_mask_reg);
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end
endmodule : frs_host

/* File: sim/frs_link_checker.sv */
`timescale 1ns/1ns
module frs_link_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic serial_out_oe,
  input wire logic serial_clock_oe_dev,
  input wire logic serial_clock_oe_host
);
  // ====================================
  // host pulls of flag2 within one readout
  logic host_d_reg;
  logic [3:0] pulls_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) host_d_reg <= 1'h0;
    else host_d_reg <= serial_clock_oe_host;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pulls_reg <= 4'h0;
    else if (serial_clock_oe_dev && !serial_clock_oe_host) pulls_reg <= 4'h0;
    else if (serial_clock_oe_host && !host_d_reg && pulls_reg != 4'hf) begin
      pulls_reg <= pulls_reg + 4'h1;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_reset_idle: assert property ($rose(presetn) |-> serial_out_oe && serial_clock_oe_dev)
    else $error("flags not low after reset");
  chk_start_when_free: assert property ($rose(serial_clock_oe_host) |-> !serial_clock_oe_dev)
    else $error("host clocked a flag held low");
  chk_pull_hold: assert property ($rose(serial_clock_oe_host) && pulls_reg < 4'ha
    |-> serial_clock_oe_host [*8])
    else $error("clock low phase too short");
  chk_release_hold: assert property ($fell(serial_clock_oe_host) && pulls_reg inside {[1:10]}
    |-> !serial_clock_oe_host [*8])
    else $error("clock high phase too short");
  chk_flag_released: assert property (pulls_reg inside {[1:10]} |-> !serial_clock_oe_dev)
    else $error("device pulled flag2 during readout");
  chk_clear_last: assert property ($rose(serial_clock_oe_host) && pulls_reg == 4'ha
    |-> ##[1:8] (serial_out_oe && serial_clock_oe_dev))
    else $error("no clear after last edge");
  chk_host_lets_go: assert property (pulls_reg == 4'hb && serial_clock_oe_dev
    |-> ##[0:60] !serial_clock_oe_host)
    else $error("host kept flag2 after clear");
  chk_bit_on_fall: assert property ($changed(serial_out_oe) && pulls_reg inside {[1:10]}
    |-> serial_clock_oe_host)
    else $error("bit changed outside clock low");
endmodule : frs_link_checker

/* File: sim/tb_top.sv */
`timescale 1ns/1ns
`include "frs_cfg.svh"
module tb_top;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic gate_regulator_rail = 1'h0, vdd = 1'h0, err, pready, pslverr, irq, ss, bs;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic [5:0] vds = 6'h0;
  logic [2:0] boot = 3'h0;
  logic [9:0] rec;
  logic [9:0] rows [6] = '{10'h001, 10'h020, 10'h02a, 10'h080, 10'h240, 10'h115};
  int err_total = 0, compares = 0;
  frs_link_if lnk();
  frs_device u_frs_device (.pclk(pclk), .presetn(presetn), .link(lnk), .vds_fault(vds),
    .gate_regulator_rail_uv(gate_regulator_rail), .boot_uv(boot), .vdd_uv(vdd), .over_temp(1'h0), .fault_record_reg(rec),
    .short_state_reg(ss), .boot_state_reg(bs));
  frs_host u_frs_host (.pclk(pclk), .presetn(presetn), .link(lnk), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq));
  frs_link_checker u_chk (.pclk(pclk), .presetn(presetn), .serial_out_oe(lnk.serial_out_oe),
    .serial_clock_oe_dev(lnk.serial_clock_oe_dev),
    .serial_clock_oe_host(lnk.serial_clock_oe_host));
  initial forever #2 pclk = ~pclk;
  // ====================================
  // tasks
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : give_verdict
  task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1 && n < 16) begin
      @(posedge pclk);
      n++;
    end
    q = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (n == 16) begin
      err_total++;
      give_verdict();
    end
    @(posedge pclk);
  endtask : apb
  task automatic readout;
    int n;
    apb(1'h1, `FRS_OFF_IRQ, 32'h3);
    apb(1'h1, `FRS_OFF_CTRL, 32'h1);
    for (n = 0; n < 400; n++) begin
      apb(1'h0, `FRS_OFF_IRQ, 32'h0);
      if (q[0] === 1'h1) break;
    end
    if (n == 400) begin
      err_total++;
      give_verdict();
    end
    apb(1'h0, `FRS_OFF_DATA, 32'h0);
  endtask : readout
  task automatic hold_faults(input logic [9:0] f);
    vds <= f[5:0];
    gate_regulator_rail <= f[6];
    boot <= f[9:7];
    repeat (3) @(posedge pclk);
    vds <= 6'h0;
    gate_regulator_rail <= 1'h0;
    boot <= 3'h0;
    repeat (8) @(posedge pclk);
  endtask : hold_faults
  // ====================================
  // main sequence
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    foreach (rows[i]) begin
      hold_faults(rows[i]);
      chk("record", rows[i], rec);
      chk("boot state", 10'(|rows[i][9:7]), 10'(bs));
      chk("flags", 10'({|rows[i][9:7], 1'b1}), 10'({lnk.serial_out_i, lnk.serial_clock_i}));
      readout();
      chk("shifted word", rows[i], q[9:0]);
      chk("cleared", 10'h0, rec);
      $display("row %0d done", i);
    end
    apb(1'h1, `FRS_OFF_MASK, 32'h3);
    @(posedge pclk);
    chk("irq masked", 10'h0, 10'(irq));
    apb(1'h1, `FRS_OFF_MASK, 32'h0);
    @(posedge pclk);
    chk("irq unmasked", 10'h1, 10'(irq));
    apb(1'h1, `FRS_OFF_IRQ, 32'h3);
    @(posedge pclk);
    chk("irq cleared", 10'h0, 10'(irq));
    apb(1'h0, 12'h020, 32'h0);
    chk("unmapped", 10'h1, 10'(err));
    apb(1'h1, `FRS_OFF_CTRL, 32'h1);
    repeat (60) @(posedge pclk);
    chk("no access", 10'h0, 10'(lnk.serial_clock_oe_host));
    $display("interrupt and refusal test done");
    vds <= 6'h01;
    repeat (5) @(posedge pclk);
    vdd <= 1'h1;
    repeat (8) @(posedge pclk);
    chk("vdd record", 10'h0, rec);
    chk("vdd flags", 10'h3, 10'({lnk.serial_out_i, lnk.serial_clock_i}));
    vds <= 6'h0;
    vdd <= 1'h0;
    repeat (8) @(posedge pclk);
    chk("vdd gone", 10'h0, 10'({lnk.serial_out_i, lnk.serial_clock_i}));
    gate_regulator_rail <= 1'h1;
    boot <= 3'h1;
    repeat (3) @(posedge pclk);
    boot <= 3'h0;
    readout();
    chk("persist word", 10'h0c0, q[9:0]);
    chk("persist flags", 10'h3, 10'({lnk.serial_out_i, lnk.serial_clock_i}));
    gate_regulator_rail <= 1'h0;
    repeat (8) @(posedge pclk);
    chk("regulator bit", 10'h040, rec);
    chk("flags clear", 10'h0, 10'({lnk.serial_out_i, lnk.serial_clock_i}));
    presetn <= 1'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    chk("reset clears", 10'h0, rec);
    $display("hand tests done");
    give_verdict();
  end
endmodule : tb_top
